// ==== rtl/flag_bank_pkg.sv ====
// constants, types and field layout for the module-level latched flag bank
// assumes a single management clock domain with an active-low module reset
//
// Behaviour
// - after reset and with no event every flag bit reads zero
// - an event latches its flag; reading the byte returns it and clears it
// - each thresholded monitor has high/low alarm and high/low warning flags
// - byte 8 bit 7 latches second command block done, bit 6 the first
// - byte 8 bit 1 latches main module firmware failure
// - byte 8 bit 0 latches any module state change; it is always supported
// - byte 9 bits 7..4 hold supply low warn, high warn, low alarm, high alarm
// - byte 9 bits 3..0 hold temperature low warn, high warn, low alarm, high alarm
// - byte 10 bits 7..4 hold the second auxiliary monitor flags in that order
// - byte 10 bits 3..0 hold the first auxiliary monitor flags in that order
// - byte 11 bits 7..4 hold the vendor monitor flags in that order
// - byte 11 bits 3..0 hold the third auxiliary monitor flags in that order
// - byte 13 is vendor custom, byte 12 and byte 8 bits 5..3 reserved
// - interrupt status bit reads one when not asserted, zero when asserted
package flag_bank_pkg;

  // byte addresses of the bank within the management memory
  localparam logic [7:0] ADDR_CMD_FW = 8'h08;
  localparam logic [7:0] ADDR_SUPPLY_TEMP = 8'h09;
  localparam logic [7:0] ADDR_AUX_ONE_TWO = 8'h0a;
  localparam logic [7:0] ADDR_AUX_THREE_VENDOR = 8'h0b;
  localparam logic [7:0] ADDR_RESERVED = 8'h0c;
  localparam logic [7:0] ADDR_VENDOR_CUSTOM = 8'h0d;

  // latched bytes held in flops: 8..11, byte n at bits 8*(n-8) upward
  localparam int FLAG_BYTES = 4;
  localparam int FLAG_BITS = 8 * FLAG_BYTES;

  // positions inside byte 8
  localparam int BIT_CMD_BLOCK2_DONE = 7;
  localparam int BIT_CMD_BLOCK1_DONE = 6;
  localparam int BIT_AUX_FW_FAIL = 2;
  localparam int BIT_MAIN_FW_FAIL = 1;
  localparam int BIT_STATE_CHANGE = 0;

  // values after reset
  localparam logic [31:0] FLAGS_RESET = 32'h0000_0000;
  localparam logic [2:0] STATE_CODE_RESET = 3'h0;
  localparam logic [7:0] READ_DATA_RESET = 8'h00;

  // byte 8 bits 5..3 are reserved and must never latch
  localparam logic [31:0] RESERVED_FLAG_MASK = 32'h0000_0038;
  localparam logic [31:0] MANDATORY_FLAG_MASK = 32'h0000_0001;

  // threshold flags of one monitor, msb first as they sit in the byte
  typedef struct packed {
    logic low_warn;
    logic high_warn;
    logic low_alarm;
    logic high_alarm;
  } threshold_flags_type;

  // one-cycle event strobes from the module's supervision logic
  typedef struct packed {
    logic cmd_block2_done_flag;
    logic cmd_block1_done_flag;
    logic aux_processor_fw_fail_flag;
    logic main_fw_fail_flag;
    threshold_flags_type supply;
    threshold_flags_type temp;
    threshold_flags_type auxb;
    threshold_flags_type auxa;
    threshold_flags_type vendor_mon;
    threshold_flags_type auxc;
  } flag_events_type;

  // byte read request from the management interface
  typedef struct packed {
    logic valid;
    logic [7:0] addr;
  } read_req_type;

  // complete state of the bank
  typedef struct packed {
    logic [31:0] flags;
    logic [2:0] prev_state;
    logic state_seen;
    logic [7:0] rd_data;
    logic rd_valid;
    logic irq_inactive;
  } bank_state_type;

endpackage

// ==== rtl/module_level_latched_flags.sv ====
// module-level latched flag bank, bytes 8 to 13 of the management memory
// assumes event strobes and read requests are synchronous to clk; the
// management interface issues one byte read per request and takes rd_data
// one cycle later
// the host must read a byte to clear it; nothing inside clears a flag alone
// an event source held high relatches every cycle, so level sources work too
module module_level_latched_flags
  import flag_bank_pkg::*;
#(
  // one bit per flag of bytes 8..11; a zero bit marks the flag unsupported
  parameter logic [31:0] SUPPORT_MASK = 32'hffff_ffc7
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire flag_events_type flag_events,
  input wire logic [2:0] module_state_code,
  input wire logic int_asserted,
  input wire read_req_type rd_req,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic irq_inactive_status
);

  // reserved bits cannot be supported and the state change flag must be
  generate
    if (((SUPPORT_MASK & RESERVED_FLAG_MASK) != 32'h0000_0000) ||
        ((SUPPORT_MASK & MANDATORY_FLAG_MASK) != MANDATORY_FLAG_MASK))
    begin : g_bad_support_mask
      $error("SUPPORT_MASK sets a reserved bit or drops the state change flag");
    end
  endgenerate

  bank_state_type state_reg;
  bank_state_type state_next;
  logic [31:0] event_vec;
  logic [31:0] clear_vec;
  logic state_changed;

  // a state change only counts once a previous code has been captured,
  // so the first cycle after reset never raises a spurious flag
  assign state_changed = state_reg.state_seen && (module_state_code != state_reg.prev_state);

  // build the event vector in register layout
  always_comb
  begin
    event_vec = 32'h0000_0000;
    event_vec[BIT_CMD_BLOCK2_DONE] = flag_events.cmd_block2_done_flag;
    event_vec[BIT_CMD_BLOCK1_DONE] = flag_events.cmd_block1_done_flag;
    event_vec[BIT_AUX_FW_FAIL] = flag_events.aux_processor_fw_fail_flag;
    event_vec[BIT_MAIN_FW_FAIL] = flag_events.main_fw_fail_flag;
    event_vec[BIT_STATE_CHANGE] = state_changed;
    event_vec[15:12] = flag_events.supply;
    event_vec[11:8] = flag_events.temp;
    event_vec[23:20] = flag_events.auxb;
    event_vec[19:16] = flag_events.auxa;
    event_vec[31:28] = flag_events.vendor_mon;
    event_vec[27:24] = flag_events.auxc;
    event_vec = event_vec & SUPPORT_MASK;
  end

  // one clear mask per latched byte, picked by the read address
  // reserved and unmapped addresses match no byte, so their reads clear nothing
  generate
    for (genvar b = 0; b < FLAG_BYTES; b++)
    begin : g_clear
      assign clear_vec[8*b +: 8] =
        (rd_req.valid && (rd_req.addr == ADDR_CMD_FW + 8'(b))) ? 8'hff : 8'h00;
    end
  endgenerate

  // next state of the whole bank
  always_comb
  begin
    state_next = state_reg;
    // or-ing the events in after the clear keeps a flag raised in the read
    // cycle; the read itself still returns the older byte, so nothing is lost
    // latch, clear on read
    state_next.flags = ((state_reg.flags & ~clear_vec) | event_vec) & SUPPORT_MASK;
    state_next.prev_state = module_state_code;
    state_next.state_seen = 1'b1;
    state_next.rd_valid = rd_req.valid;
    state_next.rd_data = READ_DATA_RESET;
    // read returns the value before this cycle's events; those show next read
    case (rd_req.addr)
      ADDR_CMD_FW: state_next.rd_data = state_reg.flags[7:0];
      ADDR_SUPPLY_TEMP: state_next.rd_data = state_reg.flags[15:8];
      ADDR_AUX_ONE_TWO: state_next.rd_data = state_reg.flags[23:16];
      ADDR_AUX_THREE_VENDOR: state_next.rd_data = state_reg.flags[31:24];
      ADDR_RESERVED: state_next.rd_data = READ_DATA_RESET;
      ADDR_VENDOR_CUSTOM: state_next.rd_data = READ_DATA_RESET;
      default: state_next.rd_data = READ_DATA_RESET;
    endcase
    if (!rd_req.valid)
    begin
      state_next.rd_data = READ_DATA_RESET;
    end
    state_next.irq_inactive = !int_asserted;
  end

  // state register; irq status resets to the not-asserted default
  // a host polling during reset sees the quiet pin level, not a false alarm
  // flags clear at reset
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg.flags <= FLAGS_RESET;
      state_reg.prev_state <= STATE_CODE_RESET;
      state_reg.state_seen <= 1'b0;
      state_reg.rd_data <= READ_DATA_RESET;
      state_reg.rd_valid <= 1'b0;
      state_reg.irq_inactive <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign rd_data = state_reg.rd_data;
  assign rd_valid = state_reg.rd_valid;
  assign irq_inactive_status = state_reg.irq_inactive;

  // checks on the bank
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // no bit rises without its event
  a_no_spurious_set: assert property (
    (state_reg.flags & ~$past(state_reg.flags) & ~$past(event_vec)) == 32'h0000_0000)
    else $error("flag set without an event");

  a_hold_until_read: assert property (
    ($past(state_reg.flags) & ~$past(clear_vec) & ~state_reg.flags) == 32'h0000_0000)
    else $error("flag dropped without a read");

  // read of byte 8 clears it
  a_read_clears_byte: assert property (
    (rd_req.valid && rd_req.addr == ADDR_CMD_FW && event_vec[7:0] == 8'h00)
    |=> (state_reg.flags[7:0] == 8'h00) && rd_valid)
    else $error("byte 8 not cleared by read");

  // read data is the byte before the clear
  a_read_returns_flags: assert property (
    (rd_req.valid && rd_req.addr == ADDR_SUPPLY_TEMP)
    |=> rd_data == $past(state_reg.flags[15:8]))
    else $error("read data does not match latched byte 9");

  a_set_beats_clear: assert property (
    ((clear_vec & event_vec) != 32'h0000_0000)
    |=> ((state_reg.flags & $past(clear_vec & event_vec)) == $past(clear_vec & event_vec)))
    else $error("event lost against clearing read");

  a_reserved_zero: assert property (
    ((state_reg.flags & (RESERVED_FLAG_MASK | ~SUPPORT_MASK)) == 32'h0000_0000))
    else $error("reserved or unsupported flag bit set");

  a_reserved_bytes_read: assert property (
    (rd_req.valid && (rd_req.addr == ADDR_RESERVED || rd_req.addr == ADDR_VENDOR_CUSTOM))
    |=> rd_valid && rd_data == 8'h00)
    else $error("reserved byte read nonzero");

  a_state_change_flag: assert property (
    (state_reg.state_seen && module_state_code != state_reg.prev_state && !clear_vec[0])
    |=> state_reg.flags[BIT_STATE_CHANGE])
    else $error("state change not latched");

  a_cmd_block_map: assert property (
    (flag_events.cmd_block2_done_flag && SUPPORT_MASK[7])
    |=> state_reg.flags[BIT_CMD_BLOCK2_DONE])
    else $error("command block 2 done not at byte 8 bit 7");

  a_supply_map: assert property (
    (flag_events.supply.low_warn && SUPPORT_MASK[15]) |=> state_reg.flags[15])
    else $error("supply low warning not at byte 9 bit 7");

  a_temp_map: assert property (
    (flag_events.temp.high_alarm && SUPPORT_MASK[8]) |=> state_reg.flags[8])
    else $error("temperature high alarm not at byte 9 bit 0");

  // aux one and two nibble order
  a_aux_ab_map: assert property (
    (flag_events.auxb.low_warn && flag_events.auxa.high_alarm
     && SUPPORT_MASK[23] && SUPPORT_MASK[16])
    |=> state_reg.flags[23] && state_reg.flags[16])
    else $error("aux monitor flags misplaced in byte 10");

  // vendor and aux three nibble order
  a_aux_c_vendor_map: assert property (
    (flag_events.vendor_mon.low_warn && flag_events.auxc.low_warn
     && SUPPORT_MASK[31] && SUPPORT_MASK[27])
    |=> state_reg.flags[31] && state_reg.flags[27])
    else $error("vendor or aux three flags misplaced in byte 11");

  // status follows the pin inverted after one cycle
  a_irq_status: assert property (
    ##1 irq_inactive_status == !$past(int_asserted))
    else $error("interrupt status not inverted pin level");

  a_answer_next_cycle: assert property (
    rd_req.valid |=> rd_valid)
    else $error("no read answer one cycle after request");

  a_idle_read_zero: assert property (
    !rd_req.valid |=> !rd_valid && rd_data == 8'h00)
    else $error("read data or valid standing without a request");

  generate
    for (genvar b = 0; b < FLAG_BYTES; b++)
    begin : g_byte_checks
      a_byte_read_data: assert property (
        (rd_req.valid && rd_req.addr == ADDR_CMD_FW + 8'(b))
        |=> rd_data == $past(state_reg.flags[8*b +: 8]))
        else $error("read data differs from latched byte");

      a_byte_read_clear: assert property (
        (rd_req.valid && rd_req.addr == ADDR_CMD_FW + 8'(b)
         && event_vec[8*b +: 8] == 8'h00)
        |=> state_reg.flags[8*b +: 8] == 8'h00)
        else $error("latched byte not cleared by its read");
    end
  endgenerate

  a_event_latches: assert property (
    (event_vec != 32'h0000_0000)
    |=> ((state_reg.flags & $past(event_vec)) == $past(event_vec)))
    else $error("event did not latch its flag");

  a_cmd_block1_map: assert property (
    (flag_events.cmd_block1_done_flag && SUPPORT_MASK[6])
    |=> state_reg.flags[BIT_CMD_BLOCK1_DONE])
    else $error("command block 1 done not at byte 8 bit 6");

  a_aux_fw_map: assert property (
    (flag_events.aux_processor_fw_fail_flag && SUPPORT_MASK[2])
    |=> state_reg.flags[BIT_AUX_FW_FAIL])
    else $error("aux firmware fault not at byte 8 bit 2");

  a_main_fw_map: assert property (
    (flag_events.main_fw_fail_flag && SUPPORT_MASK[1])
    |=> state_reg.flags[BIT_MAIN_FW_FAIL])
    else $error("main firmware fault not at byte 8 bit 1");

  a_supply_order: assert property (
    (flag_events.supply != 4'h0 && SUPPORT_MASK[15:12] == 4'hf)
    |=> (state_reg.flags[15:12] & $past(flag_events.supply))
        == $past(flag_events.supply))
    else $error("supply flags out of order in byte 9");

  a_temp_order: assert property (
    (flag_events.temp != 4'h0 && SUPPORT_MASK[11:8] == 4'hf)
    |=> (state_reg.flags[11:8] & $past(flag_events.temp))
        == $past(flag_events.temp))
    else $error("temperature flags out of order in byte 9");

  a_auxb_order: assert property (
    (flag_events.auxb != 4'h0 && SUPPORT_MASK[23:20] == 4'hf)
    |=> (state_reg.flags[23:20] & $past(flag_events.auxb))
        == $past(flag_events.auxb))
    else $error("second aux flags out of order in byte 10");

  a_auxa_order: assert property (
    (flag_events.auxa != 4'h0 && SUPPORT_MASK[19:16] == 4'hf)
    |=> (state_reg.flags[19:16] & $past(flag_events.auxa))
        == $past(flag_events.auxa))
    else $error("first aux flags out of order in byte 10");

  a_vendor_order: assert property (
    (flag_events.vendor_mon != 4'h0 && SUPPORT_MASK[31:28] == 4'hf)
    |=> (state_reg.flags[31:28] & $past(flag_events.vendor_mon))
        == $past(flag_events.vendor_mon))
    else $error("vendor monitor flags out of order in byte 11");

  a_auxc_order: assert property (
    (flag_events.auxc != 4'h0 && SUPPORT_MASK[27:24] == 4'hf)
    |=> (state_reg.flags[27:24] & $past(flag_events.auxc))
        == $past(flag_events.auxc))
    else $error("third aux flags out of order in byte 11");

  a_cmd_reserved_bits: assert property (
    (rd_req.valid && rd_req.addr == ADDR_CMD_FW) |=> rd_data[5:3] == 3'h0)
    else $error("reserved bits of byte 8 read nonzero");

  a_state_clear_race: assert property (
    (state_changed && clear_vec[BIT_STATE_CHANGE])
    |=> state_reg.flags[BIT_STATE_CHANGE])
    else $error("state change lost against clearing read");

  a_unmapped_read_zero: assert property (
    (rd_req.valid && (rd_req.addr < ADDR_CMD_FW || rd_req.addr > ADDR_VENDOR_CUSTOM))
    |=> rd_data == 8'h00)
    else $error("unmapped address read nonzero");

  a_irq_asserted_low: assert property (
    int_asserted |=> !irq_inactive_status)
    else $error("asserted interrupt not reported as zero");

  // main scenarios
  c_read_set_flag: cover property (
    rd_req.valid && rd_req.addr == ADDR_CMD_FW && state_reg.flags[7:0] != 8'h00);
  c_set_during_clear: cover property ((clear_vec & event_vec) != 32'h0000_0000);
  c_state_change: cover property (state_changed ##1 rd_req.valid && rd_req.addr == ADDR_CMD_FW);
  c_reserved_read: cover property (rd_req.valid && rd_req.addr == ADDR_VENDOR_CUSTOM);
  c_irq_asserted: cover property (int_asserted ##1 !irq_inactive_status);

endmodule

// ==== sim/host_reader.sv ====
// host model of the management interface: single byte reads of the flag bank
// assumes the bank answers exactly one cycle after it takes a request
module host_reader
  import flag_bank_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  output read_req_type rd_req
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle request line carries a junk address, never a valid one
  initial rd_req = '{valid: 1'h0, addr: 8'h55};

  // host clears flags by reading the byte
  task automatic read_byte(input logic [7:0] addr, output logic [7:0] data, output logic ok);
    @(posedge clk);
    rd_req <= '{valid: 1'h1, addr: addr};
    @(posedge clk);
    // released address shows the inverse so a stale value cannot pass for a request
    rd_req <= '{valid: 1'h0, addr: ~addr};
    #1;
    data = rd_data;
    ok = rd_valid;
  endtask
endmodule

// ==== sim/testbench.sv ====
// self-checking bench for the module-level latched flag bank
// assumes host_reader as the far side and default SUPPORT_MASK (all flags supported)
module testbench
  import flag_bank_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk;
  logic rst_b;
  flag_events_type flag_events;
  logic [2:0] module_state_code;
  logic int_asserted;
  read_req_type rd_req;
  logic [7:0] rd_data;
  logic rd_valid;
  logic irq_inactive_status;
  int bad_count;
  int checks_done;

  module_level_latched_flags dut (.clk(clk), .rst_b(rst_b), .flag_events(flag_events),
    .module_state_code(module_state_code), .int_asserted(int_asserted), .rd_req(rd_req),
    .rd_data(rd_data), .rd_valid(rd_valid), .irq_inactive_status(irq_inactive_status));

  host_reader host (.clk(clk), .rd_data(rd_data), .rd_valid(rd_valid), .rd_req(rd_req));

  // 125 MHz clock
  initial
  begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one read through the host model; the answer must come with rd_valid
  task automatic rd_check(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] data;
    logic ok;
    host.read_byte(addr, data, ok);
    check({7'h00, ok}, 8'h01);
    check(data, exp);
  endtask

  // events are one-cycle strobes, taken at the second edge
  task automatic pulse(input flag_events_type ev);
    @(posedge clk);
    flag_events <= ev;
    @(posedge clk);
    flag_events <= '0;
  endtask

  // byte layout worked out independently of the design's package fields
  function automatic logic [7:0] exp_byte(input logic [7:0] addr, input logic [27:0] ev);
    case (addr)
      8'h08: exp_byte = {ev[27], ev[26], 3'h0, ev[25], ev[24], 1'h0};
      8'h09: exp_byte = ev[23:16];
      8'h0a: exp_byte = ev[15:8];
      8'h0b: exp_byte = ev[7:0];
      default: exp_byte = 8'h00;
    endcase
  endfunction

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // watchdog: the tests need well under 2000 cycles
  initial
  begin
    #160000;
    bad_count++;
    print_verdict();
  end

  // main sequence
  initial
  begin
    logic [27:0] ev;
    logic [7:0] a;
    rst_b = 1'h0;
    flag_events = '0;
    module_state_code = 3'h3;
    int_asserted = 1'h0;
    bad_count = 0;
    checks_done = 0;
    repeat (2) @(posedge clk);
    rst_b <= 1'h1;
    for (a = 8'h08; a <= 8'h0d; a++)
      rd_check(a, 8'h00);
    check({7'h00, irq_inactive_status}, 8'h01);
    $display("test reset_values done");
    // every event bit alone: lands in its byte and bit, then clears on read
    for (int i = 0; i < 28; i++)
    begin
      ev = 28'h1 << i;
      a = (i < 24) ? 8'h0b - 8'(i / 8) : 8'h08;
      pulse(ev);
      rd_check(a, exp_byte(a, ev));
      rd_check(a, 8'h00);
    end
    $display("test bit_layout done");
    // all events at once: reserved bits and bytes stay zero
    pulse('1);
    for (a = 8'h08; a <= 8'h0d; a++)
      rd_check(a, exp_byte(a, 28'hfffffff));
    rd_check(8'h00, 8'h00);
    rd_check(8'hff, 8'h00);
    $display("test reserved done");
    @(posedge clk);
    module_state_code <= 3'h5;
    rd_check(8'h08, 8'h01);
    rd_check(8'h08, 8'h00);
    $display("test state_change done");
    // event on the very edge that takes the clearing read
    fork
      pulse(28'h0010000);
      rd_check(8'h09, 8'h00);
    join
    rd_check(8'h09, 8'h01);
    rd_check(8'h09, 8'h00);
    $display("test set_wins done");
    @(posedge clk);
    int_asserted <= 1'h1;
    repeat (2) @(posedge clk);
    #1;
    check({7'h00, irq_inactive_status}, 8'h00);
    @(posedge clk);
    int_asserted <= 1'h0;
    repeat (2) @(posedge clk);
    #1;
    check({7'h00, irq_inactive_status}, 8'h01);
    $display("test irq_status done");
    // reset in mid-run drops a pending flag
    pulse(28'h8000000);
    @(posedge clk);
    rst_b <= 1'h0;
    repeat (2) @(posedge clk);
    rst_b <= 1'h1;
    rd_check(8'h08, 8'h00);
    $display("test mid_reset done");
    print_verdict();
  end
endmodule
